// *** gdc_regs.svh ***
// constants for the gate driver controller
`ifndef GDC_REGS_SVH
`define GDC_REGS_SVH
`define GDC_CLK_HZ        10000000
`define GDC_RST_PULSE_NS  5000
`define GDC_RST_MARGIN_NS 1000
`define GDC_PULSE_CYC     ((`GDC_RST_PULSE_NS + `GDC_RST_MARGIN_NS) / 100)
`define GDC_ST_IDLE       4'h1
`define GDC_ST_RUN        4'h2
`define GDC_ST_FAULT      4'h4
`define GDC_ST_CLEAR      4'h8
`endif

// *** gdc_pkg.sv ***
// types shared by the gate driver controller
package gdc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_RUN   = 4'h2,
    ST_FAULT = 4'h4,
    ST_CLEAR = 4'h8
  } gdc_state_t;
  typedef struct packed {
    logic enable;
    logic gate_on;
    logic clear;
  } gdc_cmd_t;
endpackage

// *** gdc_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module gdc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** gdc_top.sv ***
// controller board logic driving a single-switch gate driver
// behaviour in short:
// - idle: driver reset held high, gate command held low
// - run: driver reset low, gate command follows the request one cycle
//   later; the error pin is watched only here, because the driver
//   shows no error while its reset is high
// - fault: entered on a seen error; gate low and driver reset high
//   until the user asks for a clear
// - clear: driver reset held high for a fixed number of cycles, long
//   enough for the driver to drop its error memory, then back to idle
// limitation: a fault that is still present after the clear is only
// seen again once run is re-entered, two synchroniser cycles later
// trade-off: the clear pulse carries a fixed margin above the minimum
// width instead of being tuned, so a clock up to 12 MHz can still keep it legal
`timescale 1ns/10ps
`default_nettype none
`include "gdc_regs.svh"
module gdc_top #(
  parameter int PULSE_CYC = `GDC_PULSE_CYC
) (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // user side
  input  wire logic ENABLE,
  input  wire logic GATE_REQ,
  input  wire logic CLEAR_REQ,
  input  wire logic ERR_ACTIVE_LOW,
  output var  logic FAULT,
  output var  logic CLEAR_BUSY,
  // driver pins
  input  wire logic ERROR_PIN,
  output var  logic GATE_CMD,
  output var  logic DRV_RESET
);
  // -----------------------------------------------
  // parameter checks
  // -----------------------------------------------
  // the clear counter is 16 bits wide and needs a last count above zero
  if (PULSE_CYC < 2 || PULSE_CYC > 65535) begin : g_bad_pulse
    $error("PULSE_CYC out of range");
  end

  // -----------------------------------------------
  // state decoding
  // -----------------------------------------------
  function automatic logic is_state(
    input gdc_pkg::gdc_state_t s,
    input gdc_pkg::gdc_state_t want
  );
    return (s == want);
  endfunction

  // -----------------------------------------------
  // input synchronisation
  // -----------------------------------------------
  logic       err_pin_s;
  logic       pol_s;
  wire  [1:0] sync_d = {ERROR_PIN, ERR_ACTIVE_LOW};
  logic [1:0] sync_q;

  // with the sense input tied back for bench work the pin stays idle
  gdc_sync #(.W(2)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   (sync_d),
    .q   (sync_q)
  );

  assign err_pin_s = sync_q[1];
  assign pol_s     = sync_q[0];

  // error pin polarity is a board strap, so it is followed as a level
  wire err_seen = pol_s ? ~err_pin_s : err_pin_s;

  // -----------------------------------------------
  // sequencing
  // -----------------------------------------------
  gdc_pkg::gdc_state_t state_q;
  gdc_pkg::gdc_state_t state_d;
  gdc_pkg::gdc_cmd_t   cmd_d;
  logic [15:0]         cnt_q;
  logic [15:0]         cnt_d;
  logic                fault_q;
  logic                fault_d;

  wire cnt_done = (cnt_q == 16'(PULSE_CYC - 1));

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    fault_d = fault_q;
    case (state_q)
      gdc_pkg::ST_IDLE: begin
        if (ENABLE) begin
          state_d = gdc_pkg::ST_RUN;
        end
      end
      gdc_pkg::ST_RUN: begin
        // error shows only with reset low, so sample it only here
        if (err_seen) begin
          state_d = gdc_pkg::ST_FAULT;
          fault_d = 1'b1;
        end else if (!ENABLE) begin
          state_d = gdc_pkg::ST_IDLE;
        end
      end
      gdc_pkg::ST_FAULT: begin
        if (CLEAR_REQ) begin
          state_d = gdc_pkg::ST_CLEAR;
          cnt_d   = 16'h0000;
        end
      end
      gdc_pkg::ST_CLEAR: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_done) begin
          state_d = gdc_pkg::ST_IDLE;
          fault_d = 1'b0;
          cnt_d   = 16'h0000;
        end
      end
      default: begin
        state_d = gdc_pkg::ST_IDLE;
      end
    endcase
  end

  // reset held high except in run; gate forced low outside run
  wire run_next   = is_state(state_d, gdc_pkg::ST_RUN);
  wire clear_next = is_state(state_d, gdc_pkg::ST_CLEAR);

  always_comb begin
    cmd_d.enable  = run_next;
    cmd_d.gate_on = run_next & GATE_REQ;
    cmd_d.clear   = clear_next;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= gdc_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // -----------------------------------------------
  // registered outputs
  // -----------------------------------------------
  // driver reset comes up high so the driver stays blocked from reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DRV_RESET <= 1'b1;
    end else begin
      DRV_RESET <= ~cmd_d.enable;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      GATE_CMD <= 1'b0;
    end else begin
      GATE_CMD <= cmd_d.gate_on;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FAULT <= 1'b0;
    end else begin
      FAULT <= fault_d;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CLEAR_BUSY <= 1'b0;
    end else begin
      CLEAR_BUSY <= cmd_d.clear;
    end
  end
endmodule
`default_nettype wire

// *** gdc_dev_model.sv ***
// behavioural model of the gate driver device
`timescale 1ns/10ps
`default_nettype none
module gdc_dev_model (
  // from controller
  input  wire logic rst_in,
  input  wire logic cmd_in,
  input  wire logic pol_low,
  // secondary side event
  input  wire logic short_ev, // reported after blanking
  input  wire logic uv_ev, // undervoltage already qualified
  // to controller
  output var  logic err_pin,
  output var  logic sw_on
);
  logic fault_q = 1'b0;
  // inputs taken at the default level
  // release of reset sets again a fault still present
  always @(posedge short_ev or posedge uv_ev or posedge rst_in or
           negedge rst_in)
    fault_q <= (short_ev || uv_ev) && !rst_in;
  assign err_pin = pol_low ^ (fault_q && !rst_in);
  assign sw_on = cmd_in === 1'b1 && !rst_in && !fault_q;
endmodule
`default_nettype wire

// *** gdc_top_sva.sv ***
// port assertions for the gate driver controller
`timescale 1ns/10ps
`default_nettype none
module gdc_top_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic GATE_REQ,
  input wire logic FAULT,
  input wire logic CLEAR_BUSY,
  input wire logic GATE_CMD,
  input wire logic DRV_RESET
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_gate_enabled: assert property (GATE_CMD |-> !DRV_RESET)
    else $error("gate on while driver reset high");
  a_gate_follow: assert property
    (!DRV_RESET |-> GATE_CMD == $past(GATE_REQ))
    else $error("gate command not following request");
  a_fault_block: assert property
    (FAULT |-> DRV_RESET && !GATE_CMD)
    else $error("fault not blocking gate");
  a_busy_blocks: assert property
    (CLEAR_BUSY |-> DRV_RESET && !GATE_CMD)
    else $error("driver reset low during clear");
  a_clear_width: assert property
    ($rose(CLEAR_BUSY) |-> ##50 (CLEAR_BUSY && DRV_RESET))
    else $error("clear pulse too short");
endmodule
bind gdc_top gdc_top_chk chk (.CLK(CLK), .RST(RST), .GATE_REQ(GATE_REQ),
  .FAULT(FAULT), .CLEAR_BUSY(CLEAR_BUSY), .GATE_CMD(GATE_CMD),
  .DRV_RESET(DRV_RESET));
`default_nettype wire

// *** gdc_top_tb.sv ***
// testbench for the gate driver controller
`timescale 1ns/10ps
`default_nettype none
`include "gdc_regs.svh"
module gdc_top_tb;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, req = 1'b0, clr = 1'b0;
  logic pol = 1'b0, sc = 1'b0, uv = 1'b0;
  logic fault, busy, err, cmd, drst, sw;
  int bad_count = 0, checked = 0;
  always #50 clk = ~clk;
  gdc_top dut (.CLK(clk), .RST(rst), .ENABLE(en), .GATE_REQ(req),
    .CLEAR_REQ(clr), .ERR_ACTIVE_LOW(pol), .FAULT(fault),
    .CLEAR_BUSY(busy), .ERROR_PIN(err), .GATE_CMD(cmd), .DRV_RESET(drst));
  gdc_dev_model dev (.rst_in(drst), .cmd_in(cmd), .pol_low(pol),
    .short_ev(sc), .uv_ev(uv), .err_pin(err), .sw_on(sw));
  task automatic chk(input string n, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // bounded wait; a hang ends the run
  task automatic wait_on(ref logic s, input logic v);
    for (int i = 0; i < 100 && s !== v; i++) @(negedge clk);
    if (s !== v) begin
      bad_count++;
      conclude();
    end
  endtask
  // clear pulse: driver reset must stay high for the whole pulse
  task automatic clear_pulse;
    int n;
    n = 0;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    wait_on(busy, 1'b1);
    while (busy === 1'b1 && n < 200) begin
      chk("drst", 1'b1, drst);
      @(negedge clk);
      n++;
    end
    checked++;
    if (n !== `GDC_PULSE_CYC) begin
      bad_count++;
      $display("BAD clear width expected %0d seen %0d", `GDC_PULSE_CYC, n);
      if (n >= 200) conclude();
    end
  endtask
  task automatic run_gate;
    en = 1'b1;
    @(negedge clk);
    chk("drst", 1'b0, drst);
    req = 1'b1;
    @(negedge clk);
    chk("sw", 1'b1, sw);
    req = 1'b0;
    @(negedge clk);
    chk("cmd", 1'b0, cmd);
  endtask
  // short circuit with gate held on, then clear and resume
  task automatic fault_clear(input logic p);
    pol = p;
    req = 1'b1;
    repeat (3) @(negedge clk);
    sc = 1'b1;
    #1 chk("err", ~p, err);
    @(negedge clk);
    sc = 1'b0;
    wait_on(fault, 1'b1);
    chk("cmd", 1'b0, cmd);
    clear_pulse();
    chk("fault", 1'b0, fault);
    repeat (2) @(negedge clk);
    chk("cmd", 1'b1, cmd);
  endtask
  // lasting undervoltage: fault comes back after the clear until it ends
  task automatic uv_fault;
    uv = 1'b1;
    wait_on(fault, 1'b1);
    chk("drst", 1'b1, drst);
    clear_pulse();
    wait_on(fault, 1'b1);
    chk("cmd", 1'b0, cmd);
    uv = 1'b0;
    clear_pulse();
    chk("fault", 1'b0, fault);
    repeat (2) @(negedge clk);
    chk("sw", 1'b1, sw);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    run_gate();
    fault_clear(1'b0);
    fault_clear(1'b1);
    uv_fault();
    conclude();
  end
endmodule
`default_nettype wire
